// file: core/vout_fault_pkg.sv
package vout_fault_pkg;
    // command codes of the registers held here
    localparam logic [7:0] cmd_high_warning = 8'h42;
    localparam logic [7:0] cmd_low_warning = 8'h43;
    localparam logic [7:0] cmd_low_fault = 8'h44;
    localparam logic [7:0] cmd_fault_reaction = 8'h45;
    // code of the time unit register, held outside this block
    localparam logic [7:0] cmd_time_unit = 8'hC8;
    // fields of the reaction byte
    localparam int resp_hi = 7;
    localparam int resp_lo = 6;
    localparam int retry_hi = 5;
    localparam int retry_lo = 3;
    localparam int delay_hi = 2;
    localparam int delay_lo = 0;
    // response codes
    localparam logic [1:0] resp_ignore = 2'h0;
    localparam logic [1:0] resp_run_then_retry = 2'h1;
    localparam logic [1:0] resp_disable_retry = 2'h2;
    localparam logic [1:0] resp_off_while_fault = 2'h3;
    // retry codes
    localparam logic [2:0] retry_none = 3'h0;
    localparam logic [2:0] retry_forever = 3'h7;
    // values after reset
    localparam logic [15:0] high_warning_reset = 16'hFFFF;
    localparam logic [15:0] low_warning_reset = 16'h0000;
    localparam logic [15:0] low_fault_reset = 16'h0000;
    localparam logic [7:0] fault_reaction_reset = 8'h80;
    localparam logic [23:0] timer_reset = 24'h00_0000;
    localparam logic [2:0] attempts_reset = 3'h0;
    localparam logic [15:0] rdata_reset = 16'h0000;
    // states, gray coded along off, run, delay, disabled, attempt, latched
    typedef enum logic [2:0] {
        st_off = 3'b000,
        st_run = 3'b001,
        st_fault_delay = 3'b011,
        st_disabled = 3'b010,
        st_attempt = 3'b110,
        st_latched = 3'b111,
        st_hold_off = 3'b101
    } fault_state_e;
endpackage : vout_fault_pkg

// file: core/vout_fault_retry_control.sv
`timescale 1ns/1ns
// Notes on behaviour
// - retry codes 1 to 6 give exactly that many restart attempts
// - when all attempts fail the output stays off until cleared
// - starts of consecutive attempts are delay count times time unit apart
// - retry code 7 retries forever until commanded off or another fault
// - delay field n means 2 to the n time units
// - delay is either run time after fault or spacing of attempts
// - the time unit length comes from the register at code 0xC8
// - 16-bit high warning level at code 0x42, unsigned, exponent -11
// - 16-bit low warning level at code 0x43, unsigned, exponent -11
// - 16-bit low fault level at code 0x44, unsigned, exponent -11
// - reaction byte at 0x45, response 00 ignores the fault
// - response 01 runs for the delay, then retries if fault remains
// - response 10 disables at once, then follows the retry field
// - response 11 keeps output off only while the fault lasts
// - retry code 0 makes no attempt, output off until cleared
// - fault clears by status clear, clear command, or off then on; off then on restarts but leaves fault_status set
module vout_fault_retry_control (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic wr_strobe,
    input wire logic [7:0] wr_code,
    input wire logic [15:0] wr_data,
    input wire logic rd_strobe,
    input wire logic [7:0] rd_code,
    input wire logic [15:0] time_unit_cycles,
    input wire logic [15:0] vout_measured,
    input wire logic control_pin,
    input wire logic operation_on,
    input wire logic other_fault_shutdown,
    input wire logic clear_faults,
    input wire logic clear_fault_status,
    output logic output_enable,
    output logic fault_status,
    output logic warning_status,
    output logic [15:0] rdata,
    output logic rd_valid
);
    // interval length minus one; a zero unit still gives one cycle
    function automatic logic [23:0] interval_m1(input logic [15:0] unit,
                                                input logic [2:0] n);
        logic [23:0] len;
        len = {8'h00, unit} << n;
        interval_m1 = (len == 24'h00_0000) ? 24'h00_0000 : len - 24'h00_0001;
    endfunction : interval_m1
    function automatic logic drives_output(
        input vout_fault_pkg::fault_state_e s);
        drives_output = (s == vout_fault_pkg::st_run) ||
                        (s == vout_fault_pkg::st_fault_delay) ||
                        (s == vout_fault_pkg::st_attempt);
    endfunction : drives_output
    logic [15:0] high_warning_level;
    logic [15:0] low_warning_level;
    logic [15:0] low_fault_level;
    logic [7:0] fault_reaction;
    logic ctrl_meta;
    logic ctrl_sync;
    logic [23:0] timer;
    logic [2:0] attempts;
    vout_fault_pkg::fault_state_e state;
    vout_fault_pkg::fault_state_e next_state;
    logic next_load;
    logic next_first;
    logic next_bump;
    wire [1:0] response = fault_reaction[vout_fault_pkg::resp_hi:
                                         vout_fault_pkg::resp_lo];
    wire [2:0] retries = fault_reaction[vout_fault_pkg::retry_hi:
                                        vout_fault_pkg::retry_lo];
    wire [2:0] delay_code = fault_reaction[vout_fault_pkg::delay_hi:
                                           vout_fault_pkg::delay_lo];
    // delay count as a power of two units
    // unit length from the 0xC8 register
    wire [23:0] interval = interval_m1(time_unit_cycles, delay_code);
    wire run_ok = ctrl_sync && operation_on && !other_fault_shutdown;
    wire uv_fault = vout_measured < low_fault_level;
    wire warn_now = (vout_measured > high_warning_level) ||
                    (vout_measured < low_warning_level);
    wire timer_done = timer == vout_fault_pkg::timer_reset;
    // clear paths; the off then on path runs through st_off
    wire clear_req = clear_faults || clear_fault_status;
    wire give_up = (retries != vout_fault_pkg::retry_forever) &&
                   (attempts == retries);
    wire no_retry = retries == vout_fault_pkg::retry_none;
    wire wr_high = wr_strobe && (wr_code == vout_fault_pkg::cmd_high_warning);
    wire wr_low = wr_strobe && (wr_code == vout_fault_pkg::cmd_low_warning);
    wire wr_fault = wr_strobe && (wr_code == vout_fault_pkg::cmd_low_fault);
    wire wr_react = wr_strobe &&
                    (wr_code == vout_fault_pkg::cmd_fault_reaction);
    wire rd_high = rd_code == vout_fault_pkg::cmd_high_warning;
    wire rd_low = rd_code == vout_fault_pkg::cmd_low_warning;
    wire rd_fault = rd_code == vout_fault_pkg::cmd_low_fault;
    wire rd_react = rd_code == vout_fault_pkg::cmd_fault_reaction;
    wire rd_hit = rd_high || rd_low || rd_fault || rd_react;
    wire [15:0] rd_mux = rd_high ? high_warning_level :
                         rd_low ? low_warning_level :
                         rd_fault ? low_fault_level :
                         rd_react ? {8'h00, fault_reaction} :
                         vout_fault_pkg::rdata_reset;
    always_comb begin
        next_state = state;
        next_load = 1'b0;
        next_first = 1'b0;
        next_bump = 1'b0;
        case (state)
            vout_fault_pkg::st_off: begin
                if (run_ok) begin
                    next_state = vout_fault_pkg::st_run;
                end
            end
            vout_fault_pkg::st_run: begin
                if (uv_fault) begin
                    case (response)
                        vout_fault_pkg::resp_ignore: begin
                            next_state = vout_fault_pkg::st_run;
                        end
                        vout_fault_pkg::resp_run_then_retry: begin
                            next_state = vout_fault_pkg::st_fault_delay;
                            next_load = 1'b1;
                        end
                        vout_fault_pkg::resp_disable_retry: begin
                            next_state = no_retry ?
                                vout_fault_pkg::st_latched :
                                vout_fault_pkg::st_disabled;
                            next_load = 1'b1;
                        end
                        default: begin
                            next_state = vout_fault_pkg::st_hold_off;
                        end
                    endcase
                end
            end
            vout_fault_pkg::st_fault_delay: begin
                if (timer_done) begin
                    next_load = 1'b1;
                    next_state = !uv_fault ? vout_fault_pkg::st_run :
                                 no_retry ? vout_fault_pkg::st_latched :
                                 vout_fault_pkg::st_disabled;
                end
            end
            // delay used as spacing before first attempt
            vout_fault_pkg::st_disabled: begin
                if (timer_done) begin
                    next_state = vout_fault_pkg::st_attempt;
                    next_load = 1'b1;
                    next_first = 1'b1;
                end
            end
            vout_fault_pkg::st_attempt: begin
                if (timer_done) begin
                    if (!uv_fault) begin
                        next_state = vout_fault_pkg::st_run;
                    end else if (give_up) begin
                        next_state = vout_fault_pkg::st_latched;
                    end else begin
                        next_load = 1'b1;
                        next_bump = 1'b1;
                    end
                end
            end
            vout_fault_pkg::st_latched: begin
                if (clear_req) begin
                    next_state = vout_fault_pkg::st_run;
                end
            end
            vout_fault_pkg::st_hold_off: begin
                if (!uv_fault) begin
                    next_state = vout_fault_pkg::st_run;
                end
            end
            default: begin
                next_state = vout_fault_pkg::st_off;
            end
        endcase
        // commanded off or another fault stops everything
        if (!run_ok) begin
            next_state = vout_fault_pkg::st_off;
        end
    end
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            ctrl_meta <= 1'b0;
            ctrl_sync <= 1'b0;
        end else begin
            ctrl_meta <= control_pin;
            ctrl_sync <= ctrl_meta;
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            high_warning_level <= vout_fault_pkg::high_warning_reset;
            low_warning_level <= vout_fault_pkg::low_warning_reset;
            low_fault_level <= vout_fault_pkg::low_fault_reset;
            fault_reaction <= vout_fault_pkg::fault_reaction_reset;
        end else begin
            if (wr_high) high_warning_level <= wr_data;
            if (wr_low) low_warning_level <= wr_data;
            if (wr_fault) low_fault_level <= wr_data;
            if (wr_react) fault_reaction <= wr_data[7:0];
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            rdata <= vout_fault_pkg::rdata_reset;
            rd_valid <= 1'b0;
        end else begin
            rdata <= rd_strobe ? rd_mux : rdata;
            rd_valid <= rd_strobe && rd_hit;
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            state <= vout_fault_pkg::st_off;
            timer <= vout_fault_pkg::timer_reset;
            attempts <= vout_fault_pkg::attempts_reset;
            output_enable <= 1'b0;
        end else begin
            state <= next_state;
            timer <= next_load ? interval :
                     timer_done ? timer : timer - 24'h00_0001;
            attempts <= next_first ? 3'h1 :
                        (next_bump && !(&attempts)) ? attempts + 3'h1 :
                        attempts;
            output_enable <= drives_output(next_state);
        end
    end

    // sticky fault flag: a new fault wins over a clear in the same cycle
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            fault_status <= 1'b0;
            warning_status <= 1'b0;
        end else begin
            fault_status <= uv_fault || (fault_status && !clear_req);
            warning_status <= warn_now;
        end
    end

    chk_ignore_keeps_on: assert property (
        @(posedge clk_sys) disable iff (reset) state == vout_fault_pkg::st_run
        && uv_fault && run_ok && response == vout_fault_pkg::resp_ignore
        |=> output_enable) else $error("ignored fault turned output off");
    chk_disable_now: assert property (
        @(posedge clk_sys) disable iff (reset) state == vout_fault_pkg::st_run
        && uv_fault && response == vout_fault_pkg::resp_disable_retry
        |=> !output_enable) else $error("output not disabled on fault");
    chk_hold_reenable: assert property (
        @(posedge clk_sys) disable iff (reset) !uv_fault && run_ok &&
        state == vout_fault_pkg::st_hold_off |=> output_enable &&
        state == vout_fault_pkg::st_run) else $error("output not restored");
    chk_latched_holds: assert property (
        @(posedge clk_sys) disable iff (reset) !clear_req && run_ok &&
        state == vout_fault_pkg::st_latched |=> !output_enable &&
        state == vout_fault_pkg::st_latched) else $error("latched state left");
    chk_retry_limit: assert property (
        @(posedge clk_sys) disable iff (reset) timer_done && uv_fault &&
        state == vout_fault_pkg::st_attempt && run_ok && attempts == retries
        && retries != vout_fault_pkg::retry_forever |=>
        state == vout_fault_pkg::st_latched) else $error("retry limit lost");
    chk_retry_forever: assert property (
        @(posedge clk_sys) disable iff (reset) timer_done && uv_fault &&
        state == vout_fault_pkg::st_attempt && run_ok &&
        retries == vout_fault_pkg::retry_forever |=> timer == $past(interval)
        && state == vout_fault_pkg::st_attempt) else $error("retry stopped");
    chk_spacing_load: assert property (
        @(posedge clk_sys) disable iff (reset) state == vout_fault_pkg::st_run
        && uv_fault && run_ok && !no_retry && response ==
        vout_fault_pkg::resp_disable_retry |=> timer == $past(interval) &&
        state == vout_fault_pkg::st_disabled) else $error("spacing wrong");
    chk_clear_exits: assert property (
        @(posedge clk_sys) disable iff (reset) clear_req && run_ok &&
        state == vout_fault_pkg::st_latched |=> output_enable)
        else $error("clear did not restart output");
    chk_warn_flag: assert property (
        @(posedge clk_sys) disable iff (reset) vout_measured >
        high_warning_level |=> warning_status)
        else $error("high warning not flagged");
    chk_fault_level: assert property (
        @(posedge clk_sys) disable iff (reset) wr_fault |=>
        low_fault_level == $past(wr_data)) else $error("fault level lost");
endmodule : vout_fault_retry_control

// file: bench/host_model.sv
`timescale 1ns/1ns
module host_model (
    input wire logic clk_sys,
    output logic wr_strobe,
    output logic [7:0] wr_code,
    output logic [15:0] wr_data,
    output logic rd_strobe,
    output logic [7:0] rd_code,
    output logic clear_faults,
    output logic clear_fault_status
);
    initial begin
        wr_strobe = 1'b0;
        rd_strobe = 1'b0;
        wr_code = 8'h00;
        rd_code = 8'h00;
        wr_data = 16'h0000;
        clear_faults = 1'b0;
        clear_fault_status = 1'b0;
    end
    // one-cycle strobe, held over one edge
    task automatic access(input logic wr, input logic [7:0] code,
        input logic [15:0] data);
        @(negedge clk_sys);
        wr_strobe = wr;
        rd_strobe = !wr;
        wr_code = code;
        rd_code = code;
        wr_data = data;
        @(negedge clk_sys);
        wr_strobe = 1'b0;
        rd_strobe = 1'b0;
        // stale data is inverted so it never looks valid
        wr_data = ~data;
    endtask : access
    // clear by command or by status bit
    task automatic clear(input logic by_cmd);
        @(negedge clk_sys);
        clear_faults = by_cmd;
        clear_fault_status = !by_cmd;
        @(negedge clk_sys);
        clear_faults = 1'b0;
        clear_fault_status = 1'b0;
    endtask : clear
endmodule : host_model

// file: bench/vout_fault_retry_control_bench.sv
`timescale 1ns/1ns
module vout_fault_retry_control_bench;
    logic clk_sys, reset, wr_strobe, rd_strobe, rd_valid;
    logic clear_faults, clear_fault_status, control_pin, operation_on;
    logic other_fault_shutdown, output_enable, fault_status;
    logic warning_status;
    logic [7:0] wr_code, rd_code;
    logic [15:0] wr_data, time_unit_cycles, vout_measured, rdata;
    logic [15:0] exp_q[$];
    logic [31:0] seed;
    int fails, checked, unit, ival, n, c;
    localparam logic [15:0] vtab [5] = '{16'h2000, 16'h3001, 16'h17FF,
        16'h3000, 16'h1800};
    localparam logic wtab [5] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
    localparam int ntab [5] = '{0, 1, 3, 6, 7};
    // delay codes include both end points of the power of two table
    localparam int dtab [5] = '{1, 0, 7, 2, 1};
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    host_model host (.clk_sys(clk_sys), .wr_strobe(wr_strobe),
        .wr_code(wr_code), .wr_data(wr_data), .rd_strobe(rd_strobe),
        .rd_code(rd_code), .clear_faults(clear_faults),
        .clear_fault_status(clear_fault_status));
    vout_fault_retry_control dut (.clk_sys(clk_sys), .reset(reset),
        .wr_strobe(wr_strobe), .wr_code(wr_code), .wr_data(wr_data),
        .rd_strobe(rd_strobe), .rd_code(rd_code),
        .time_unit_cycles(time_unit_cycles), .vout_measured(vout_measured),
        .control_pin(control_pin), .operation_on(operation_on),
        .other_fault_shutdown(other_fault_shutdown),
        .clear_faults(clear_faults), .clear_fault_status(clear_fault_status),
        .output_enable(output_enable), .fault_status(fault_status),
        .warning_status(warning_status), .rdata(rdata), .rd_valid(rd_valid));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task automatic wrap_up();
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : wrap_up
    task automatic check_val(input string what, input logic [15:0] e,
        input logic [15:0] g);
        checked++;
        if (g !== e) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", what, e, g);
        end
    endtask : check_val
    task automatic check_cnt(input string what, input int e, input int g);
        checked++;
        if (g != e) begin
            fails++;
            $display("MISMATCH %s expected %0d seen %0d", what, e, g);
        end
    endtask : check_cnt
    // decision edge may add up to two cycles to a span
    task automatic check_near(input string what, input int e, input int g);
        check_cnt(what, e, (g >= e && g <= e + 2) ? e : g);
    endtask : check_near
    task automatic run_len(input logic lvl, input int lim, input bit must,
        output int cnt);
        cnt = 0;
        while (output_enable === lvl && cnt < lim) begin
            @(negedge clk_sys);
            cnt++;
        end
        if (must && cnt >= lim) begin
            fails++;
            $display("MISMATCH wait_output expected change seen none");
            wrap_up();
        end
    endtask : run_len
    task automatic rd(input logic [7:0] code, input logic [15:0] e);
        exp_q.push_back(e);
        host.access(1'b0, code, 16'h0000);
    endtask : rd
    task automatic restore();
        vout_measured = 16'h2000;
        other_fault_shutdown = 1'b0;
        host.clear(1'b1);
        run_len(1'b0, 12, 1, c);
    endtask : restore
    always @(posedge clk_sys) begin
        #1;
        if (rd_valid === 1'b1) begin
            if (exp_q.size() == 0) begin
                check_val("rd_valid", 16'h0000, 16'h0001);
            end else begin
                check_val("rdata", exp_q.pop_front(), rdata);
            end
        end
    end
    initial begin
        reset = 1'b1;
        control_pin = 1'b1;
        operation_on = 1'b1;
        other_fault_shutdown = 1'b0;
        vout_measured = 16'h2000;
        time_unit_cycles = 16'h0001;
        fails = 0;
        checked = 0;
        seed = 32'hb7b5;
        repeat (2) @(negedge clk_sys);
        reset = 1'b0;
        rd(8'h42, vout_fault_pkg::high_warning_reset);
        rd(8'h43, vout_fault_pkg::low_warning_reset);
        rd(8'h44, vout_fault_pkg::low_fault_reset);
        rd(8'h45, {8'h00, vout_fault_pkg::fault_reaction_reset});
        for (int i = 0; i < 4; i++) begin
            seed = lfsr(seed);
            host.access(1'b1, 8'h42 + 8'(i), seed[15:0]);
            rd(8'h42 + 8'(i),
                i == 3 ? {8'h00, seed[7:0]} : seed[15:0]);
        end
        host.access(1'b0, 8'h46, 16'h0000);
        check_val("unmapped", 16'h0000, rdata);
        $display("test registers done");
        host.access(1'b1, 8'h42, 16'h3000);
        host.access(1'b1, 8'h43, 16'h1800);
        host.access(1'b1, 8'h44, 16'h1000);
        host.access(1'b1, 8'h45, 16'h0000);
        restore();
        for (int i = 0; i < 5; i++) begin
            vout_measured = vtab[i];
            repeat (3) @(negedge clk_sys);
            check_val("warning", 16'(wtab[i]), 16'(warning_status));
        end
        vout_measured = 16'h0800;
        run_len(1'b1, 40, 0, c);
        check_cnt("ignore on", 40, c);
        other_fault_shutdown = 1'b1;
        run_len(1'b1, 3, 1, c);
        check_val("shutdown", 16'h0000, {15'h0, output_enable});
        restore();
        $display("test warning and ignore done");
        for (int k = 0; k < 5; k++) begin
            n = ntab[k];
            seed = lfsr(seed);
            unit = 1 + int'(seed[1:0]) % 3;
            time_unit_cycles = 16'(unit);
            ival = unit << dtab[k];
            host.access(1'b1, 8'h45, {8'h00, 2'b10, 3'(n), 3'(dtab[k])});
            vout_measured = 16'h0800;
            run_len(1'b1, 4, 0, c);
            if (n != 0) begin
                run_len(1'b0, 2000, 1, c);
                check_cnt("retry gap", ival, c);
                run_len(1'b1, n == 7 ? 20 * ival : 2000, n != 7, c);
                if (n == 7) begin
                    check_cnt("endless", 20 * ival, c);
                    operation_on = 1'b0;
                    run_len(1'b1, 3, 1, c);
                end else begin
                    check_near("attempts", n * ival, c);
                end
            end
            run_len(1'b0, 40, 0, c);
            check_cnt("latched", 40, c);
            check_val("fault", 16'h0001, {15'h0, fault_status});
            vout_measured = 16'h2000;
            operation_on = 1'b1;
            if (k % 3 == 2) begin
                control_pin = 1'b0;
                repeat (5) @(negedge clk_sys);
                control_pin = 1'b1;
            end else begin
                host.clear(k % 3 == 0);
            end
            run_len(1'b0, 12, 1, c);
            check_val("restart", 16'h0001, {15'h0, output_enable});
            if (k % 3 != 2) begin
                check_val("cleared", 16'h0000, {15'h0, fault_status});
            end
        end
        $display("test retry table done");
        time_unit_cycles = 16'h0002;
        host.access(1'b1, 8'h45, 16'h0042);
        vout_measured = 16'h0800;
        run_len(1'b1, 100, 1, c);
        check_near("run delay", 8, c);
        run_len(1'b0, 40, 0, c);
        check_cnt("run latched", 40, c);
        restore();
        host.access(1'b1, 8'h45, 16'h00C0);
        vout_measured = 16'h0800;
        run_len(1'b1, 4, 0, c);
        run_len(1'b0, 30, 0, c);
        check_cnt("off in fault", 30, c);
        vout_measured = 16'h2000;
        run_len(1'b0, 4, 1, c);
        check_val("resume", 16'h0001, {15'h0, output_enable});
        $display("test delay and hold off done");
        for (int i = 0; i < 10 && exp_q.size() != 0; i++) begin
            @(negedge clk_sys);
        end
        check_cnt("reads left", 0, exp_q.size());
        wrap_up();
    end
endmodule : vout_fault_retry_control_bench
